//--- rtl/qdsw_pkg.sv
/*
 * Shared constants and types for the quad DAC serial write port.
 * Assumes both link ends and the bench compile this package first.
 */
package qdsw_pkg;
    // Frame layout, most significant bit sent first.
    localparam int FRAME_BITS = 24;
    localparam int CMD_HI = 21;
    localparam int CMD_LO = 19;
    localparam int ADDR_HI = 18;
    localparam int ADDR_LO = 16;
    localparam int DATA_HI = 15;
    localparam int PD_MODE_HI = 5;
    localparam int PD_MODE_LO = 4;
    localparam int RST_FULL_BIT = 0;
    localparam int NUM_CH = 4;
    localparam int DATA_BITS_DEF = 16;

    // Command and address codes.
    localparam logic [2:0] CMD_WR_IN = 3'h0;
    localparam logic [2:0] CMD_UPD = 3'h1;
    localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
    localparam logic [2:0] CMD_WR_UPD = 3'h3;
    localparam logic [2:0] CMD_PWR = 3'h4;
    localparam logic [2:0] CMD_RST = 3'h5;
    localparam logic [2:0] CMD_LOAD_MASK = 3'h6;
    localparam logic [2:0] ADDR_ALL = 3'h7;

    // Timing: core clock and link limits.
    localparam int CORE_PERIOD_NS = 100;
    localparam int SYNC_HIGH_MIN_NS = 15;
    localparam int SYNC_HIGH_RAW = (SYNC_HIGH_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int SYNC_HIGH_CYC = (SYNC_HIGH_RAW < 1) ? 1 : SYNC_HIGH_RAW;
    localparam int SCLK_MAX_MHZ = 50;
    localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
    localparam int SCLK_HALF_DEF = 1;
    localparam int BUF_DEPTH_DEF = 2;

    typedef enum logic [1:0] {QDSW_IDLE, QDSW_SHIFT, QDSW_GAP} qdsw_host_state_t;

    // True when an address field selects the given channel.
    function automatic logic qdsw_hit(input logic [2:0] addr, input int ch);
        return (addr == ADDR_ALL) || (addr == 3'(ch));
    endfunction
endpackage

//--- rtl/qdsw_link_if.sv
/*
 * Three-wire write link between host and DAC.
 * Assumes the host drives all three wires; the DAC only listens.
 */
`timescale 1ns/1ps
interface qdsw_link_if;
    logic frame_sel_n;
    logic sclk;
    logic din;

    modport host (output frame_sel_n, output sclk, output din);
    modport dev (input frame_sel_n, input sclk, input din);
endinterface

//--- rtl/qdsw_buf2.sv
/*
 * Small first-in first-out buffer with valid and ready on both sides.
 * Assumes one clock; in_ready and out_valid come straight from flops.
 */
`timescale 1ns/1ps
module qdsw_buf2
    import qdsw_pkg::*;
#(
    parameter int WIDTH = FRAME_BITS,
    parameter int DEPTH = BUF_DEPTH_DEF
)
(
    input wire logic core_clk, // Core clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic in_valid, // Producer offers a word.
    output logic in_ready, // Room for a word.
    input wire logic [WIDTH-1:0] in_data, // Word offered.
    output logic out_valid, // A word is waiting.
    input wire logic out_ready, // Consumer takes the word.
    output logic [WIDTH-1:0] out_data // Oldest word.
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointer wrap relies on a power-of-two depth.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
        $error("qdsw_buf2 needs a power-of-two depth of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic next_in_ready, next_out_valid;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Pointers and count; the flags are precomputed so ports see flops only.
    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
        next_in_ready = (next_count != (AW + 1)'(DEPTH));
        next_out_valid = (next_count != '0);
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    // Storage needs no reset; nothing reads an entry before it is written.
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

//--- rtl/qdsw_host.sv
/*
 * Host end: queues 24-bit frames and shifts them out on the link.
 * Assumes the link clock is made here by dividing core_clk.
 */
`timescale 1ns/1ps
module qdsw_host
    import qdsw_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF
)
(
    input wire logic core_clk, // Core clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic cmd_valid, // A frame is offered.
    output logic cmd_ready, // Queue has room.
    input wire logic [FRAME_BITS-1:0] cmd_word, // Frame to send.
    qdsw_link_if.host link // Serial link.
);
    localparam int HW = (SCLK_HALF > 1) ? $clog2(SCLK_HALF) : 1;

    if (SCLK_HALF < 1 || 2 * SCLK_HALF * CORE_PERIOD_NS < SCLK_MIN_PERIOD_NS)
    begin
        $error("qdsw_host link clock would run too fast");
    end

    logic buf_valid, buf_ready;
    logic [FRAME_BITS-1:0] buf_word;

    // The queue drains only while idle, so a busy shifter stalls the user once the queue holds two frames.
    qdsw_buf2 #(.WIDTH(FRAME_BITS), .DEPTH(BUF_DEPTH_DEF)) u_buf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_word),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_word)
    );

    qdsw_host_state_t state, next_state;
    logic [FRAME_BITS-1:0] shreg, next_shreg;
    logic [HW-1:0] div, next_div;
    logic [4:0] bits, next_bits;
    logic [7:0] gap, next_gap;
    logic sel_n, next_sel_n, sclk, next_sclk;

    assign buf_ready = (state == QDSW_IDLE);
    assign link.frame_sel_n = sel_n;
    assign link.sclk = sclk;
    assign link.din = shreg[FRAME_BITS-1];

    // Frame sequencer; data moves on rising edges, the DAC samples falling.
    always_comb
    begin
        next_state = state;
        next_shreg = shreg;
        next_div = div;
        next_bits = bits;
        next_gap = gap;
        next_sel_n = sel_n;
        next_sclk = sclk;
        unique case (state)
            QDSW_IDLE:
            begin
                if (buf_valid)
                begin
                    next_sel_n = 1'b0;
                    next_shreg = buf_word;
                    next_div = '0;
                    next_bits = '0;
                    next_state = QDSW_SHIFT;
                end
            end
            QDSW_SHIFT:
            begin
                next_div = div + 1'b1;
                if (div == HW'(SCLK_HALF - 1))
                begin
                    next_div = '0;
                    next_sclk = ~sclk;
                    if (sclk)
                        next_bits = bits + 5'h01;
                    else if (bits == 5'(FRAME_BITS))
                    begin
                        next_sel_n = 1'b1;
                        next_gap = 8'(SYNC_HIGH_CYC - 1);
                        next_state = QDSW_GAP;
                    end
                    else
                        next_shreg = {shreg[FRAME_BITS-2:0], 1'b0};
                end
            end
            QDSW_GAP:
            begin
                next_gap = gap - 8'h01;
                if (gap == 8'h00)
                    next_state = QDSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= QDSW_IDLE;
            shreg <= '0;
            div <= '0;
            bits <= '0;
            gap <= '0;
            sel_n <= 1'b1;
            sclk <= 1'b1;
        end
        else
        begin
            state <= next_state;
            shreg <= next_shreg;
            div <= next_div;
            bits <= next_bits;
            gap <= next_gap;
            sel_n <= next_sel_n;
            sclk <= next_sclk;
        end
    end
endmodule

//--- rtl/qdsw_dev.sv
/*
 * DAC end: serial shift register on the link clock and the command
 * executor with input, DAC, power-down and strobe-mask registers on
 * core_clk.
 * Assumes the host keeps the link timing; the link clock may stop
 * between frames.
 */
// Behaviour
// - Host lowers select before any clock.
// - Shift data in on falling clock.
// - Execute command on 24th falling edge.
// - Select may stay low or rise after.
// - Select high at least 15 ns between.
// - New frame only on select falling.
// - Host may park select low between frames.
// - Link clock no faster than 50 MHz.
// - Codes are unsigned straight binary.
// - MSB first: spare, command, address, data.
// - Early select rise discards the frame.
// - Decode seven commands, code 7 reserved, and channel addresses.
`timescale 1ns/1ps
module qdsw_dev
    import qdsw_pkg::*;
#(
    parameter int DATA_BITS = DATA_BITS_DEF
)
(
    input wire logic core_clk, // Core clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic load_all_strobe_n, // Strobe pin, falling edge loads all.
    qdsw_link_if.dev link, // Serial link.
    output logic [NUM_CH-1:0][DATA_BITS-1:0] dac_code, // DAC register codes.
    output logic [NUM_CH-1:0][1:0] pd_mode, // Per-channel power mode.
    output logic [NUM_CH-1:0] load_mask, // Strobe-mask register.
    output logic cmd_done // Pulse when a frame is executed.
);
    if (DATA_BITS != 12 && DATA_BITS != 16)
    begin
        $error("qdsw_dev supports 12 or 16 data bits only");
    end

    // ---- Link domain, clocked by falling edges of the link clock. ----
    logic link_clear;
    logic [4:0] edge_cnt, next_edge_cnt;
    logic [FRAME_BITS-2:0] shreg, next_shreg;
    logic frame_full, next_frame_full;
    logic [FRAME_BITS-1:0] link_word, next_link_word;
    logic link_tog, next_link_tog;
    logic last_edge;

    // A high select or a core reset clears the frame at once, clock or not.
    assign link_clear = link.frame_sel_n | ~reset_n;
    assign last_edge = !frame_full && edge_cnt == 5'(FRAME_BITS - 1);

    // Shift and count; full frames lock out further edges until select rises.
    always_comb
    begin
        next_shreg = shreg;
        next_edge_cnt = edge_cnt;
        next_frame_full = frame_full;
        if (!frame_full)
        begin
            next_shreg = {shreg[FRAME_BITS-3:0], link.din};
            next_edge_cnt = edge_cnt + 5'h01;
        end
        if (last_edge)
            next_frame_full = 1'b1;
    end

    always_ff @(negedge link.sclk or posedge link_clear)
    begin
        if (link_clear)
        begin
            shreg <= '0;
            edge_cnt <= '0;
            frame_full <= 1'b0;
        end
        else
        begin
            shreg <= next_shreg;
            edge_cnt <= next_edge_cnt;
            frame_full <= next_frame_full;
        end
    end

    // The finished word stays put for the whole next frame, which gives the
    // core many cycles to read it after the toggle has been synchronised.
    always_comb
    begin
        next_link_word = link_word;
        next_link_tog = link_tog;
        if (last_edge)
        begin
            next_link_word = {shreg, link.din};
            next_link_tog = ~link_tog;
        end
    end

    always_ff @(negedge link.sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_word <= '0;
            link_tog <= 1'b0;
        end
        else
        begin
            link_word <= next_link_word;
            link_tog <= next_link_tog;
        end
    end

    // ---- Core domain. ----
    logic tog_s1, tog_s2, tog_s3;
    logic ld_s1, ld_s2, ld_s3;
    logic word_new, strobe_fall;

    // Two-flop synchronisers; the third flop only serves edge detection.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            ld_s1 <= 1'b1;
            ld_s2 <= 1'b1;
            ld_s3 <= 1'b1;
        end
        else
        begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            ld_s1 <= load_all_strobe_n;
            ld_s2 <= ld_s1;
            ld_s3 <= ld_s2;
        end
    end

    assign word_new = tog_s2 ^ tog_s3;
    assign strobe_fall = ld_s3 & ~ld_s2;

    logic [NUM_CH-1:0][DATA_BITS-1:0] in_reg, next_in_reg, next_dac_code;
    logic [NUM_CH-1:0][1:0] next_pd_mode;
    logic [NUM_CH-1:0] next_load_mask;
    logic next_cmd_done;
    logic [2:0] cmd, addr;
    logic [DATA_BITS-1:0] code;

    assign cmd = link_word[CMD_HI:CMD_LO];
    assign addr = link_word[ADDR_HI:ADDR_LO];
    assign code = link_word[DATA_HI -: DATA_BITS];

    // Command executor; the strobe pin acts after any command in the same
    // cycle so a write and a strobe together still load the new code.
    always_comb
    begin
        next_in_reg = in_reg;
        next_dac_code = dac_code;
        next_pd_mode = pd_mode;
        next_load_mask = load_mask;
        next_cmd_done = 1'b0;
        if (word_new)
        begin
            next_cmd_done = 1'b1;
            case (cmd)
                CMD_WR_IN, CMD_WR_UPD, CMD_WR_UPD_ALL:
                begin
                    for (int ch = 0; ch < NUM_CH; ch++)
                    begin
                        if (qdsw_hit(addr, ch))
                        begin
                            next_in_reg[ch] = code;
                            if (cmd == CMD_WR_UPD || load_mask[ch])
                                next_dac_code[ch] = code;
                        end
                    end
                    if (cmd == CMD_WR_UPD_ALL)
                        next_dac_code = next_in_reg;
                end
                CMD_UPD:
                begin
                    for (int ch = 0; ch < NUM_CH; ch++)
                    begin
                        if (qdsw_hit(addr, ch))
                            next_dac_code[ch] = in_reg[ch];
                    end
                end
                CMD_PWR:
                begin
                    for (int ch = 0; ch < NUM_CH; ch++)
                    begin
                        if (link_word[ch])
                            next_pd_mode[ch] = link_word[PD_MODE_HI:PD_MODE_LO];
                    end
                end
                CMD_RST:
                begin
                    next_dac_code = '0;
                    if (link_word[RST_FULL_BIT])
                    begin
                        next_in_reg = '0;
                        next_pd_mode = '0;
                        next_load_mask = '0;
                    end
                end
                CMD_LOAD_MASK:
                    next_load_mask = link_word[NUM_CH-1:0];
                default:
                    // Reserved code: the frame is accepted but does nothing.
                    next_cmd_done = 1'b1;
            endcase
        end
        if (strobe_fall)
            next_dac_code = next_in_reg;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            in_reg <= '0;
            dac_code <= '0;
            pd_mode <= '0;
            load_mask <= '0;
            cmd_done <= 1'b0;
        end
        else
        begin
            in_reg <= next_in_reg;
            dac_code <= next_dac_code;
            pd_mode <= next_pd_mode;
            load_mask <= next_load_mask;
            cmd_done <= next_cmd_done;
        end
    end
endmodule

//--- tb/qdsw_link_monitor.sv
/*
 * Wire checker for the three-wire write link between host and DAC ends.
 * Assumes the host drives the link from core_clk flops.
 */
`timescale 1ns/1ps
module qdsw_link_monitor (
    input wire logic core_clk, // Core clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic frame_sel_n, // Frame select, active low.
    input wire logic sclk, // Link clock.
    input wire logic din // Serial data.
);
    logic sclk_q;
    logic [4:0] falls;
    logic [4:0] next_falls;

    // Falling link clock edges in this frame; cleared while select is high.
    always_comb
    begin
        next_falls = falls;
        if (frame_sel_n)
            next_falls = 5'h00;
        else if (sclk_q && !sclk)
            next_falls = falls + 5'h01;
    end

    // Registers the edge counter and the last link clock level.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_q <= 1'b1;
            falls <= 5'h00;
        end
        else
        begin
            sclk_q <= sclk;
            falls <= next_falls;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_clock_in_frame: assert property ($fell(sclk) |-> !frame_sel_n)
        else $error("link clock fell outside a frame");
    a_idle_clock_high: assert property (frame_sel_n |-> sclk)
        else $error("link clock not high while idle");
    a_first_fall_next: assert property ($fell(frame_sel_n) |=> $fell(sclk))
        else $error("first clock fall late after select");
    a_gap_before_start: assert property ($fell(frame_sel_n) |-> $past(frame_sel_n, 2))
        else $error("select high gap too short");
    a_frame_length: assert property ($rose(frame_sel_n) |-> falls == 5'h18)
        else $error("frame did not carry 24 clock falls");
    a_release_after_last: assert property (
        (!frame_sel_n && sclk_q && !sclk && falls == 5'h17) |=> $rose(frame_sel_n))
        else $error("select not released after last bit");
    a_data_held: assert property ($fell(sclk) |-> $stable(din))
        else $error("data changed at clock fall");
    a_clock_rate: assert property ($fell(sclk) |=> $rose(sclk))
        else $error("link clock low phase wrong");
endmodule

//--- tb/test_quad_dac_serial_write_port.sv
/*
 * Self-checking bench: host and 16-bit DAC ends joined by the link, and a
 * second 12-bit DAC end driven by the bench to break the framing.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/1ps
module test_quad_dac_serial_write_port;
    import qdsw_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [23:0] cmd_word = 24'h000000;
    logic strobe_n = 1'b1;
    logic cmd_ready;
    logic [NUM_CH-1:0][15:0] dac_code;
    logic [NUM_CH-1:0][1:0] pd_mode;
    logic [NUM_CH-1:0] load_mask;
    logic cmd_done;
    logic [NUM_CH-1:0][11:0] code12;
    logic done12;
    int failures = 0;
    int checked = 0;
    int dones = 0;
    int dones12 = 0;
    int nf = 0;
    qdsw_link_if link();
    qdsw_link_if bad_link();

    qdsw_host qdsw_host_inst (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_word(cmd_word), .link(link.host));
    qdsw_dev qdsw_dev_inst (.core_clk(core_clk), .reset_n(reset_n),
        .load_all_strobe_n(strobe_n), .link(link.dev), .dac_code(dac_code),
        .pd_mode(pd_mode), .load_mask(load_mask), .cmd_done(cmd_done));
    qdsw_dev #(.DATA_BITS(12)) qdsw_dev_inst2 (.core_clk(core_clk), .reset_n(reset_n),
        .load_all_strobe_n(1'b1), .link(bad_link.dev), .dac_code(code12),
        .pd_mode(), .load_mask(), .cmd_done(done12));
    qdsw_link_monitor qdsw_link_monitor_inst (.core_clk(core_clk), .reset_n(reset_n),
        .frame_sel_n(link.frame_sel_n), .sclk(link.sclk), .din(link.din));

    // Core clock, 100 ns period.
    always #50 core_clk = ~core_clk;

    // Counts completion pulses of both DAC ends.
    always @(posedge core_clk)
    begin
        if (cmd_done === 1'b1)
            dones <= dones + 1;
        if (done12 === 1'b1)
            dones12 <= dones12 + 1;
    end

    function automatic logic [23:0] fr(input logic [2:0] c, input logic [2:0] a,
        input logic [15:0] d);
        return {2'b11, c, a, d}; // Spare bits set to show they are ignored.
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Offers one frame and holds it until the queue takes it.
    task automatic send(input logic [23:0] w);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        nf++;
        @(posedge core_clk);
        while (cmd_ready !== 1'b1)
            @(posedge core_clk);
    endtask

    // Waits, bounded, until every frame sent has been executed.
    task automatic drain();
        int i;
        cmd_valid <= 1'b0;
        for (i = 0; i < 600 && dones < nf; i++)
            @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk("frames executed", 16'(nf), 16'(dones));
    endtask

    // Drives the spare link by hand at a 48 ns clock; fewer than 24 falls aborts.
    task automatic drive_frame(input logic [23:0] w, input int n);
        int i;
        bad_link.frame_sel_n = 1'b1;
        #24 bad_link.frame_sel_n = 1'b0;
        #24;
        for (i = 0; i < n; i++)
        begin
            bad_link.din = w[23 - (i % 24)];
            #24 bad_link.sclk = 1'b0;
            #24 bad_link.sclk = 1'b1;
        end
        bad_link.din = ~bad_link.din;
        #24 bad_link.frame_sel_n = 1'b1;
        #800;
    endtask

    task automatic test_write_update();
        logic [15:0] codes [4] = '{16'hFFFF, 16'h0000, 16'h7FFF, 16'h8000};
        for (int i = 0; i < 4; i++)
            send(fr(CMD_WR_UPD, 3'(i), codes[i]));
        drain();
        for (int i = 0; i < 4; i++)
            chk("dac code", codes[i], dac_code[i]);
        $display("test_write_update finished");
    endtask

    task automatic test_input_update();
        send(fr(CMD_WR_IN, 3'h1, 16'h1234));
        drain();
        chk("dac held", 16'h0000, dac_code[1]);
        send(fr(CMD_UPD, 3'h1, 16'h0000));
        send(fr(CMD_WR_UPD_ALL, 3'h2, 16'h0ABC));
        send(fr(3'h7, ADDR_ALL, 16'h5555));
        send(fr(CMD_WR_UPD, 3'h4, 16'h5555));
        drain();
        chk("dac ch0", 16'hFFFF, dac_code[0]);
        chk("dac ch1", 16'h1234, dac_code[1]);
        chk("dac ch2", 16'h0ABC, dac_code[2]);
        chk("dac ch3", 16'h8000, dac_code[3]);
        $display("test_input_update finished");
    endtask

    task automatic test_pd_mask_strobe();
        send(fr(CMD_PWR, 3'h0, 16'h0025));
        send(fr(CMD_LOAD_MASK, 3'h0, 16'h0003));
        send(fr(CMD_WR_IN, ADDR_ALL, 16'h0F0F));
        drain();
        chk("power mode", 16'h0022, 16'(pd_mode));
        chk("strobe mask", 16'h0003, 16'(load_mask));
        chk("masked ch1", 16'h0F0F, dac_code[1]);
        chk("unmasked ch2", 16'h0ABC, dac_code[2]);
        strobe_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        strobe_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("strobed ch3", 16'h0F0F, dac_code[3]);
        send(fr(CMD_RST, 3'h0, 16'h0000));
        drain();
        chk("soft dac", 16'h0000, dac_code[0] | dac_code[1] | dac_code[2] | dac_code[3]);
        chk("soft reset keeps", 16'h0223, {4'h0, pd_mode, load_mask});
        send(fr(CMD_RST, 3'h0, 16'h0001));
        drain();
        chk("reset dac", 16'h0000, dac_code[0] | dac_code[1] | dac_code[2] | dac_code[3]);
        chk("reset mode", 16'h0000, {4'h0, pd_mode, load_mask});
        $display("test_pd_mask_strobe finished");
    endtask

    task automatic test_abort();
        drive_frame(fr(CMD_WR_UPD, 3'h0, 16'h1230), 23);
        chk("aborted frame", 16'h0000, 16'(dones12));
        chk("aborted code", 16'h0000, 16'(code12[0]));
        drive_frame(fr(CMD_WR_UPD, 3'h0, 16'hABCD), 48);
        chk("one execute", 16'h0001, 16'(dones12));
        chk("12-bit code", 16'h0ABC, 16'(code12[0]));
        bad_link.frame_sel_n = 1'b0;
        #400;
        drive_frame(fr(CMD_WR_UPD, 3'h3, 16'h5A5A), 24);
        chk("parked frames", 16'h0002, 16'(dones12));
        chk("parked code", 16'h05A5, 16'(code12[3]));
        $display("test_abort finished");
    endtask

    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: reset for four cycles, then each test in turn.
    initial
    begin
        bad_link.frame_sel_n = 1'b1;
        bad_link.sclk = 1'b1;
        bad_link.din = 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        test_write_update();
        test_input_update();
        test_pd_mask_strobe();
        test_abort();
        finish_test();
    end

    // Watchdog: the tests need well under 2000 cycles.
    initial
    begin
        #3000000;
        failures++;
        finish_test();
    end
endmodule
